/* File: logic/bfmr_top.sv */
`timescale 1ns/1ns
//Function
//RULE1: controller pulses both master resets after power-up
//RULE2: reset spans four edges of each clock
//RULE3: asynchronous reset inputs are synchronised first
//RULE4: reset returns both pointers to zero
//RULE5: reset drives full and empty flags low
//RULE6: reset drives almost-empty flag low
//RULE7: reset drives almost-full flag high
//RULE8: reset forces that mailbox flag high
//RULE9: input ready rises two write edges later
//RULE10: fifo1 release captures endian select
//RULE11: fifo1 release captures offset selects, program mode
//RULE12: fifo2 release clears fifo2 offset registers
//RULE13: joint release captures configuration for device
//RULE14: port edges set and clear mailbox flags
//RULE15: mailbox1 write shows on port B
//RULE16: mailbox2 write shows on port A
//RULE17: mailbox select switches outputs without edge
//RULE18: port A drives when select, direction low
//RULE19: port B drives when select low, direction high
//RULE20: captured endian high big, low little
//RULE21: next write edge samples timing, high standard
//RULE22: low sampled selects fall-through timing
//RULE23: reset edges counted per port domain
module bfmr_top import bfmr_pkg::*; #(
   parameter int DATA_W = BFMR_DATA_W,
   parameter int ADDR_W = BFMR_ADDR_W,
   parameter int ALMOST_OFS = BFMR_ALMOST_OFS
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_fifo1_master_reset_n,
   input wire logic i_fifo2_master_reset_n,
   input wire logic i_port_a_clock,
   input wire logic i_port_b_clock,
   input wire logic i_endian_timing_select_pin,
   input wire logic i_offset_select_0,
   input wire logic i_offset_select_1,
   input wire logic i_serial_program_mode_n,
   input wire logic i_port_a_chip_select_n,
   input wire logic i_port_a_direction,
   input wire logic i_port_a_enable,
   input wire logic i_port_a_mailbox_select,
   input wire logic [DATA_W-1:0] i_port_a_data,
   input wire logic i_port_b_chip_select_n,
   input wire logic i_port_b_direction,
   input wire logic i_port_b_enable,
   input wire logic i_port_b_mailbox_select,
   input wire logic [DATA_W-1:0] i_port_b_data,
   input wire logic [DATA_W-1:0] i_fifo1_read_data,
   input wire logic [DATA_W-1:0] i_fifo2_read_data,
   output logic [DATA_W-1:0] o_port_a_data,
   output logic o_port_a_data_oe_n,
   output logic [DATA_W-1:0] o_port_b_data,
   output logic o_port_b_data_oe_n,
   output logic o_port_a_full_or_in_ready,
   output logic o_port_b_full_or_in_ready,
   output logic o_port_a_empty_or_out_ready,
   output logic o_port_b_empty_or_out_ready,
   output logic o_port_a_almost_empty_n,
   output logic o_port_b_almost_empty_n,
   output logic o_port_a_almost_full_n,
   output logic o_port_b_almost_full_n,
   output logic o_mailbox1_flag_n,
   output logic o_mailbox2_flag_n,
   output logic o_endian_select,
   output logic o_offset_select_0,
   output logic o_offset_select_1,
   output logic o_serial_program_mode_n,
   output logic o_fifo1_fall_through_timing,
   output logic o_fifo2_fall_through_timing,
   output logic [BFMR_OFFSET_W-1:0] o_fifo2_almost_empty_offset,
   output logic [BFMR_OFFSET_W-1:0] o_fifo2_almost_full_offset,
   output logic [ADDR_W:0] o_fifo1_write_ptr,
   output logic [ADDR_W:0] o_fifo1_read_ptr,
   output logic [ADDR_W:0] o_fifo2_write_ptr,
   output logic [ADDR_W:0] o_fifo2_read_ptr
);
   localparam logic [ADDR_W:0] DEPTH_V = (ADDR_W+1)'(1) << ADDR_W;
   localparam logic [ADDR_W:0] OFS_V = (ADDR_W+1)'(ALMOST_OFS);

   function automatic logic [ADDR_W:0] fill(input logic [ADDR_W:0] wr, input logic [ADDR_W:0] rd);
      fill = wr - rd;
   endfunction

   // synchronisers and edge detection; index 0 is fifo1 (A to B), 1 is fifo2
   logic [1:0] rst_meta_reg, rst_sync_reg, rst_prev_reg;
   logic port_a_clock_prev_reg, port_b_clock_prev_reg;
   logic a_edge, b_edge;
   logic [1:0] rise, wedge, redge;

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         // idle (released) level, so leaving i_reset shows no false release edge
         rst_meta_reg <= 2'h3;
         rst_sync_reg <= 2'h3;
         rst_prev_reg <= 2'h3;
         port_a_clock_prev_reg <= 1'b0;
         port_b_clock_prev_reg <= 1'b0;
      end else begin
         rst_meta_reg <= {i_fifo2_master_reset_n, i_fifo1_master_reset_n}; // see RULE3
         rst_sync_reg <= rst_meta_reg; // see RULE3
         rst_prev_reg <= rst_sync_reg;
         port_a_clock_prev_reg <= i_port_a_clock;
         port_b_clock_prev_reg <= i_port_b_clock;
      end
   end

   always_comb begin
      a_edge = i_port_a_clock & ~port_a_clock_prev_reg;
      b_edge = i_port_b_clock & ~port_b_clock_prev_reg;
      rise = rst_sync_reg & ~rst_prev_reg;
      wedge = {b_edge, a_edge};
      redge = {a_edge, b_edge};
   end

   // port strobes
   logic a_sel, b_sel;
   logic [1:0] wr_ok, rd_ok;
   logic mw1, mr1, mw2, mr2;
   always_comb begin
      a_sel = ~i_port_a_chip_select_n & i_port_a_enable;
      b_sel = ~i_port_b_chip_select_n & i_port_b_enable;
      mw1 = a_edge & a_sel & i_port_a_direction & i_port_a_mailbox_select;
      mr2 = a_edge & a_sel & ~i_port_a_direction & i_port_a_mailbox_select;
      mw2 = b_edge & b_sel & ~i_port_b_direction & i_port_b_mailbox_select;
      mr1 = b_edge & b_sel & i_port_b_direction & i_port_b_mailbox_select;
      wr_ok[0] = a_edge & a_sel & i_port_a_direction & ~i_port_a_mailbox_select;
      rd_ok[1] = a_edge & a_sel & ~i_port_a_direction & ~i_port_a_mailbox_select;
      wr_ok[1] = b_edge & b_sel & ~i_port_b_direction & ~i_port_b_mailbox_select;
      rd_ok[0] = b_edge & b_sel & i_port_b_direction & ~i_port_b_mailbox_select;
   end

   // reset sequencer and flags, one copy per fifo
   bfmr_state_t st_reg [2], st_next [2];
   logic [2:0] cnta_reg [2], cnta_next [2], cntb_reg [2], cntb_next [2];
   logic [1:0] wait_reg [2], wait_next [2];
   logic [1:0] tsel_reg, tsel_next, ft_reg, ft_next;
   logic [ADDR_W:0] wp_reg [2], wp_next [2], rp_reg [2], rp_next [2];
   logic [ADDR_W:0] fill_w [2];
   logic [1:0] full_reg, full_next, empty_reg, empty_next;
   logic [1:0] ae_n_reg, ae_n_next, af_n_reg, af_n_next;

   always_comb begin
      for (int f = 0; f < 2; f++) begin
         st_next[f] = st_reg[f];
         cnta_next[f] = cnta_reg[f];
         cntb_next[f] = cntb_reg[f];
         wait_next[f] = wait_reg[f];
         tsel_next[f] = tsel_reg[f];
         ft_next[f] = ft_reg[f];
         wp_next[f] = wp_reg[f];
         rp_next[f] = rp_reg[f];
         case (st_reg[f])
            ST_RUN: begin
               if (!rst_sync_reg[f]) begin
                  st_next[f] = ST_RESET;
                  cnta_next[f] = BFMR_CNT_CLEAR;
                  cntb_next[f] = BFMR_CNT_CLEAR;
               end else begin
                  if (wr_ok[f] && full_reg[f]) begin
                     wp_next[f] = wp_reg[f] + (ADDR_W+1)'(1);
                  end
                  if (rd_ok[f] && empty_reg[f]) begin
                     rp_next[f] = rp_reg[f] + (ADDR_W+1)'(1);
                  end
               end
            end
            ST_RESET: begin
               // edges are counted separately for each port clock
               if (!rst_sync_reg[f]) begin
                  if (a_edge && cnta_reg[f] != BFMR_RESET_EDGES) begin
                     cnta_next[f] = cnta_reg[f] + 3'h1; // see RULE2, RULE23
                  end
                  if (b_edge && cntb_reg[f] != BFMR_RESET_EDGES) begin
                     cntb_next[f] = cntb_reg[f] + 3'h1; // see RULE2, RULE23
                  end
               end else if (cnta_reg[f] == BFMR_RESET_EDGES
                            && cntb_reg[f] == BFMR_RESET_EDGES) begin
                  st_next[f] = ST_WAIT; // see RULE2
                  wait_next[f] = BFMR_WAIT_CLEAR;
                  tsel_next[f] = 1'b1;
               end else begin
                  // short pulse: the next pulse must count its own four edges
                  cnta_next[f] = BFMR_CNT_CLEAR; // see RULE2
                  cntb_next[f] = BFMR_CNT_CLEAR; // see RULE2
               end
            end
            ST_WAIT: begin
               if (!rst_sync_reg[f]) begin
                  st_next[f] = ST_RESET;
                  cnta_next[f] = BFMR_CNT_CLEAR;
                  cntb_next[f] = BFMR_CNT_CLEAR;
               end else if (wedge[f]) begin
                  if (tsel_reg[f]) begin
                     ft_next[f] = ~i_endian_timing_select_pin; // see RULE21, RULE22
                     tsel_next[f] = 1'b0;
                  end
                  wait_next[f] = wait_reg[f] + 2'h1;
                  if (wait_reg[f] == BFMR_READY_EDGES - 2'h1) begin
                     st_next[f] = ST_RUN; // see RULE9
                  end
               end
            end
            default: begin
               st_next[f] = ST_RESET;
            end
         endcase
         if (st_next[f] != ST_RUN) begin
            wp_next[f] = '0; // see RULE4
            rp_next[f] = '0; // see RULE4
         end
         fill_w[f] = fill(wp_next[f], rp_next[f]);
         if (st_next[f] != ST_RUN) begin
            full_next[f] = 1'b0; // see RULE5
            empty_next[f] = 1'b0; // see RULE5
            ae_n_next[f] = 1'b0; // see RULE6
            af_n_next[f] = 1'b1; // see RULE7
         end else begin
            full_next[f] = ~fill_w[f][ADDR_W]; // see RULE9
            empty_next[f] = fill_w[f] != '0;
            ae_n_next[f] = fill_w[f] > OFS_V;
            af_n_next[f] = (DEPTH_V - fill_w[f]) > OFS_V;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         for (int f = 0; f < 2; f++) begin
            st_reg[f] <= ST_RESET;
            cnta_reg[f] <= BFMR_CNT_CLEAR;
            cntb_reg[f] <= BFMR_CNT_CLEAR;
            wait_reg[f] <= BFMR_WAIT_CLEAR;
            wp_reg[f] <= '0;
            rp_reg[f] <= '0;
         end
         tsel_reg <= 2'h0;
         ft_reg <= {2{BFMR_FT_RESET}};
         full_reg <= 2'h0;
         empty_reg <= 2'h0;
         ae_n_reg <= 2'h0;
         af_n_reg <= 2'h3;
      end else begin
         for (int f = 0; f < 2; f++) begin
            st_reg[f] <= st_next[f];
            cnta_reg[f] <= cnta_next[f];
            cntb_reg[f] <= cntb_next[f];
            wait_reg[f] <= wait_next[f];
            wp_reg[f] <= wp_next[f];
            rp_reg[f] <= rp_next[f];
         end
         tsel_reg <= tsel_next;
         ft_reg <= ft_next;
         full_reg <= full_next;
         empty_reg <= empty_next;
         ae_n_reg <= ae_n_next;
         af_n_reg <= af_n_next;
      end
   end

   // mailboxes, configuration latches and port outputs
   logic [DATA_W-1:0] mbox1_reg, mbox1_next, mbox2_reg, mbox2_next;
   logic mailbox1_flag_n_reg, mailbox1_flag_n_next, mailbox2_flag_n_reg, mailbox2_flag_n_next;
   logic endian_reg, endian_next, fs0_reg, fs0_next, fs1_reg, fs1_next, spm_reg, spm_next;
   logic [BFMR_OFFSET_W-1:0] xofs_reg, xofs_next, yofs_reg, yofs_next;
   logic [DATA_W-1:0] adata_reg, adata_next, bdata_reg, bdata_next;
   logic aoe_n_reg, aoe_n_next, boe_n_reg, boe_n_next;

   always_comb begin
      mbox1_next = mw1 ? i_port_a_data : mbox1_reg;
      mbox2_next = mw2 ? i_port_b_data : mbox2_reg;
      // a write beats a read landing in the same cycle, so no message is lost
      if (st_next[0] == ST_RESET) begin
         mailbox1_flag_n_next = 1'b1; // see RULE8
      end else begin
         mailbox1_flag_n_next = mw1 ? 1'b0 : (mr1 ? 1'b1 : mailbox1_flag_n_reg); // see RULE14
      end
      if (st_next[1] == ST_RESET) begin
         mailbox2_flag_n_next = 1'b1; // see RULE8
      end else begin
         mailbox2_flag_n_next = mw2 ? 1'b0 : (mr2 ? 1'b1 : mailbox2_flag_n_reg); // see RULE14
      end
      endian_next = rise[0] ? i_endian_timing_select_pin : endian_reg; // see RULE10, RULE13, RULE20
      fs0_next = rise[0] ? i_offset_select_0 : fs0_reg; // see RULE11, RULE13
      fs1_next = rise[0] ? i_offset_select_1 : fs1_reg; // see RULE11, RULE13
      spm_next = rise[0] ? i_serial_program_mode_n : spm_reg; // see RULE11, RULE13
      xofs_next = rise[1] ? BFMR_OFFSET_CLEAR : xofs_reg; // see RULE12
      yofs_next = rise[1] ? BFMR_OFFSET_CLEAR : yofs_reg; // see RULE12
      // select muxes the live mailbox value, no port clock edge involved
      adata_next = i_port_a_mailbox_select ? mbox2_next : i_fifo2_read_data; // see RULE16, RULE17
      bdata_next = i_port_b_mailbox_select ? mbox1_next : i_fifo1_read_data; // see RULE15, RULE17
      aoe_n_next = i_port_a_chip_select_n | i_port_a_direction; // see RULE18
      boe_n_next = i_port_b_chip_select_n | ~i_port_b_direction; // see RULE19
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         mbox1_reg <= '0;
         mbox2_reg <= '0;
         mailbox1_flag_n_reg <= BFMR_MBF_N_RESET;
         mailbox2_flag_n_reg <= BFMR_MBF_N_RESET;
         endian_reg <= BFMR_ENDIAN_RESET;
         fs0_reg <= BFMR_FSEL_RESET;
         fs1_reg <= BFMR_FSEL_RESET;
         spm_reg <= BFMR_SPM_N_RESET;
         xofs_reg <= BFMR_OFFSET_RESET;
         yofs_reg <= BFMR_OFFSET_RESET;
         adata_reg <= '0;
         bdata_reg <= '0;
         aoe_n_reg <= 1'b1;
         boe_n_reg <= 1'b1;
      end else begin
         mbox1_reg <= mbox1_next;
         mbox2_reg <= mbox2_next;
         mailbox1_flag_n_reg <= mailbox1_flag_n_next;
         mailbox2_flag_n_reg <= mailbox2_flag_n_next;
         endian_reg <= endian_next;
         fs0_reg <= fs0_next;
         fs1_reg <= fs1_next;
         spm_reg <= spm_next;
         xofs_reg <= xofs_next;
         yofs_reg <= yofs_next;
         adata_reg <= adata_next;
         bdata_reg <= bdata_next;
         aoe_n_reg <= aoe_n_next;
         boe_n_reg <= boe_n_next;
      end
   end

   assign o_port_a_data = adata_reg;
   assign o_port_b_data = bdata_reg;
   assign o_port_a_data_oe_n = aoe_n_reg;
   assign o_port_b_data_oe_n = boe_n_reg;
   assign o_port_a_full_or_in_ready = full_reg[0];
   assign o_port_b_full_or_in_ready = full_reg[1];
   assign o_port_b_empty_or_out_ready = empty_reg[0];
   assign o_port_a_empty_or_out_ready = empty_reg[1];
   assign o_port_b_almost_empty_n = ae_n_reg[0];
   assign o_port_a_almost_empty_n = ae_n_reg[1];
   assign o_port_a_almost_full_n = af_n_reg[0];
   assign o_port_b_almost_full_n = af_n_reg[1];
   assign o_mailbox1_flag_n = mailbox1_flag_n_reg;
   assign o_mailbox2_flag_n = mailbox2_flag_n_reg;
   assign o_endian_select = endian_reg;
   assign o_offset_select_0 = fs0_reg;
   assign o_offset_select_1 = fs1_reg;
   assign o_serial_program_mode_n = spm_reg;
   assign o_fifo1_fall_through_timing = ft_reg[0];
   assign o_fifo2_fall_through_timing = ft_reg[1];
   assign o_fifo2_almost_empty_offset = xofs_reg;
   assign o_fifo2_almost_full_offset = yofs_reg;
   assign o_fifo1_write_ptr = wp_reg[0];
   assign o_fifo1_read_ptr = rp_reg[0];
   assign o_fifo2_write_ptr = wp_reg[1];
   assign o_fifo2_read_ptr = rp_reg[1];

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   sequence s_f1_last_wait;
      st_reg[0] == ST_WAIT && wait_reg[0] == 2'h1 && rst_sync_reg[0] && a_edge;
   endsequence
   sequence s_f1_released;
      st_reg[0] == ST_RESET && st_next[0] == ST_WAIT;
   endsequence

   a_reset_edge_count: assert property (s_f1_released |-> cnta_reg[0] == 3'h4 && cntb_reg[0] == 3'h4) else $error("fifo1 reset ended short of edges"); // see RULE2
   a_ready_two_edges: assert property (s_f1_last_wait |=> o_port_a_full_or_in_ready) else $error("input ready late"); // see RULE9
   a_flags_in_reset: assert property (st_reg[1] == ST_RESET |-> !o_port_b_full_or_in_ready && !o_port_a_empty_or_out_ready && !o_port_a_almost_empty_n && o_port_b_almost_full_n) else $error("fifo2 reset flags wrong"); // see RULE5, RULE6, RULE7
   a_ptr_cleared: assert property (st_reg[0] == ST_RESET |-> o_fifo1_write_ptr == '0 && o_fifo1_read_ptr == '0) else $error("fifo1 pointers not cleared"); // see RULE4
   a_mbf_reset: assert property (st_reg[0] == ST_RESET |-> o_mailbox1_flag_n) else $error("mailbox1 flag low in reset"); // see RULE8
   a_mbox_write: assert property (mw1 && st_next[0] != ST_RESET |=> !o_mailbox1_flag_n) else $error("mailbox1 write not flagged"); // see RULE14
   a_mbox_bypass: assert property (mw1 && i_port_b_mailbox_select |=> o_port_b_data == $past(i_port_a_data)) else $error("mailbox1 data not on port B"); // see RULE15
   a_oe_port_a: assert property (!o_port_a_data_oe_n |-> $past(!i_port_a_chip_select_n && !i_port_a_direction)) else $error("port A driven wrongly"); // see RULE18
   a_oe_port_b: assert property (!o_port_b_data_oe_n |-> $past(!i_port_b_chip_select_n && i_port_b_direction)) else $error("port B driven wrongly"); // see RULE19
   a_endian_capture: assert property (rise[0] |=> o_endian_select == $past(i_endian_timing_select_pin)) else $error("endian not captured"); // see RULE10
   a_offset_clear: assert property (rise[1] |=> o_fifo2_almost_empty_offset == '0 && o_fifo2_almost_full_offset == '0) else $error("fifo2 offsets not cleared"); // see RULE12
   a_timing_sample: assert property (st_reg[1] == ST_WAIT && tsel_reg[1] && rst_sync_reg[1] && b_edge |=> o_fifo2_fall_through_timing == !$past(i_endian_timing_select_pin)) else $error("timing mode not sampled"); // see RULE21, RULE22
endmodule

/* File: pkg/bfmr_pkg.sv */
package bfmr_pkg;
   // default widths and depth of the block
   localparam int BFMR_DATA_W = 36;
   localparam int BFMR_ADDR_W = 8;
   localparam int BFMR_OFFSET_W = 10;
   localparam int BFMR_ALMOST_OFS = 8;
   // edges of each port clock that a master reset must span
   localparam logic [2:0] BFMR_RESET_EDGES = 3'h4;
   localparam logic [2:0] BFMR_CNT_CLEAR = 3'h0;
   // write clock edges from release to input ready
   localparam logic [1:0] BFMR_READY_EDGES = 2'h2;
   localparam logic [1:0] BFMR_WAIT_CLEAR = 2'h0;
   // reset values
   localparam logic BFMR_ENDIAN_RESET = 1'b0;
   localparam logic BFMR_FSEL_RESET = 1'b0;
   localparam logic BFMR_SPM_N_RESET = 1'b1;
   localparam logic BFMR_FT_RESET = 1'b0;
   localparam logic BFMR_MBF_N_RESET = 1'b1;
   localparam logic [BFMR_OFFSET_W-1:0] BFMR_OFFSET_RESET = 10'h3ff;
   localparam logic [BFMR_OFFSET_W-1:0] BFMR_OFFSET_CLEAR = 10'h000;
   typedef enum logic [1:0] {ST_RUN, ST_RESET, ST_WAIT} bfmr_state_t;
endpackage

/* File: test/bfmr_bus_model.sv */
`timescale 1ns/1ns
module bfmr_bus_model #(
   parameter int DATA_W = 36,
   parameter int A_HALF = 20,
   parameter int B_HALF = 30
) (
   output logic o_port_a_clock,
   output logic o_port_b_clock,
   output logic o_a_chip_select_n,
   output logic o_a_direction,
   output logic o_a_enable,
   output logic o_a_mailbox_select,
   output logic [DATA_W-1:0] o_a_data,
   output logic o_b_chip_select_n,
   output logic o_b_direction,
   output logic o_b_enable,
   output logic o_b_mailbox_select,
   output logic [DATA_W-1:0] o_b_data
);
   initial begin
      o_port_a_clock = 1'b0;
      o_port_b_clock = 1'b0;
      {o_a_chip_select_n, o_a_direction, o_a_enable, o_a_mailbox_select} = 4'h8;
      {o_b_chip_select_n, o_b_direction, o_b_enable, o_b_mailbox_select} = 4'h8;
      o_a_data = '0;
      o_b_data = '0;
   end
   // free-running port clocks, both slower than the system clock the block samples them with
   always #A_HALF o_port_a_clock = ~o_port_a_clock;
   always #B_HALF o_port_b_clock = ~o_port_b_clock;
   // change after a falling edge, hold through the rising edge that takes the request
   task automatic a_cycle(input logic cs_n, input logic dir, input logic en, input logic mb,
                          input logic [DATA_W-1:0] data);
      @(negedge o_port_a_clock);
      o_a_chip_select_n = cs_n;
      o_a_direction = dir;
      o_a_enable = en;
      o_a_mailbox_select = mb;
      // an idle bus must not keep showing the last word
      o_a_data = en ? data : ~o_a_data;
      @(posedge o_port_a_clock);
   endtask
   task automatic b_cycle(input logic cs_n, input logic dir, input logic en, input logic mb,
                          input logic [DATA_W-1:0] data);
      @(negedge o_port_b_clock);
      o_b_chip_select_n = cs_n;
      o_b_direction = dir;
      o_b_enable = en;
      o_b_mailbox_select = mb;
      o_b_data = en ? data : ~o_b_data;
      @(posedge o_port_b_clock);
   endtask
endmodule

/* File: test/bfmr_top_tb_top.sv */
`timescale 1ns/1ns
module bfmr_top_tb_top;
   import bfmr_pkg::*;
   localparam int W = BFMR_DATA_W;
   int num_errors = 0;
   int cmp_count = 0;
   logic i_sys_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_fifo1_master_reset_n = 1'b1;
   logic i_fifo2_master_reset_n = 1'b1;
   logic i_endian_timing_select_pin = 1'b1;
   logic i_offset_select_0 = 1'b0;
   logic i_offset_select_1 = 1'b0;
   logic i_serial_program_mode_n = 1'b1;
   logic [W-1:0] i_fifo1_read_data = 36'h0a5a5a5a5;
   logic [W-1:0] i_fifo2_read_data = 36'h05a5a5a5a;
   logic i_port_a_clock, i_port_b_clock, i_port_a_chip_select_n, i_port_a_direction;
   logic i_port_a_enable, i_port_a_mailbox_select, i_port_b_chip_select_n, i_port_b_direction;
   logic i_port_b_enable, i_port_b_mailbox_select;
   logic [W-1:0] i_port_a_data, i_port_b_data, o_port_a_data, o_port_b_data;
   logic o_port_a_data_oe_n, o_port_b_data_oe_n, o_port_a_full_or_in_ready;
   logic o_port_b_full_or_in_ready, o_port_a_empty_or_out_ready, o_port_b_empty_or_out_ready;
   logic o_port_a_almost_empty_n, o_port_b_almost_empty_n, o_port_a_almost_full_n;
   logic o_port_b_almost_full_n, o_mailbox1_flag_n, o_mailbox2_flag_n, o_endian_select;
   logic o_offset_select_0, o_offset_select_1, o_serial_program_mode_n;
   logic o_fifo1_fall_through_timing, o_fifo2_fall_through_timing;
   logic [BFMR_OFFSET_W-1:0] o_fifo2_almost_empty_offset, o_fifo2_almost_full_offset;
   logic [BFMR_ADDR_W:0] o_fifo1_write_ptr, o_fifo1_read_ptr, o_fifo2_write_ptr, o_fifo2_read_ptr;

   always #5 i_sys_clk = ~i_sys_clk;

   bfmr_top u_bfmr_top (.*);

   bfmr_bus_model u_bfmr_bus_model (
      .o_port_a_clock(i_port_a_clock),
      .o_port_b_clock(i_port_b_clock),
      .o_a_chip_select_n(i_port_a_chip_select_n),
      .o_a_direction(i_port_a_direction),
      .o_a_enable(i_port_a_enable),
      .o_a_mailbox_select(i_port_a_mailbox_select),
      .o_a_data(i_port_a_data),
      .o_b_chip_select_n(i_port_b_chip_select_n),
      .o_b_direction(i_port_b_direction),
      .o_b_enable(i_port_b_enable),
      .o_b_mailbox_select(i_port_b_mailbox_select),
      .o_b_data(i_port_b_data)
   );

   task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // holds the selected resets low over bedges port B edges, then lets go on a port A edge
   task automatic mreset(input logic m1, input logic m2, input int bedges, input logic pin,
                         input logic [2:0] fs_spm);
      @(negedge i_sys_clk);
      i_endian_timing_select_pin = pin;
      {i_offset_select_0, i_offset_select_1, i_serial_program_mode_n} = fs_spm;
      i_fifo1_master_reset_n = ~m1;
      i_fifo2_master_reset_n = ~m2;
      repeat (bedges) @(posedge i_port_b_clock);
      cyc(4);
      if (m1) begin
         check({o_port_a_full_or_in_ready, o_port_b_empty_or_out_ready, o_port_b_almost_empty_n,
                o_port_a_almost_full_n, o_mailbox1_flag_n}, 36'h3, "fifo1 flags");
         check({o_fifo1_write_ptr, o_fifo1_read_ptr}, 36'h0, "fifo1 pointers");
      end
      if (m2) begin
         check({o_port_b_full_or_in_ready, o_port_a_empty_or_out_ready, o_port_a_almost_empty_n,
                o_port_b_almost_full_n, o_mailbox2_flag_n}, 36'h3, "fifo2 flags");
         check({o_fifo2_write_ptr, o_fifo2_read_ptr}, 36'h0, "fifo2 pointers");
      end
      // released right on a port A edge so the next one is a full period away
      @(posedge i_port_a_clock);
      i_fifo1_master_reset_n = 1'b1;
      i_fifo2_master_reset_n = 1'b1;
   endtask

   task automatic t_power_up();
      check({o_fifo2_almost_empty_offset, o_fifo2_almost_full_offset}, 36'hfffff, "offsets");
      mreset(1'b1, 1'b1, 1, 1'b1, 3'h1);
      repeat (8) @(posedge i_port_a_clock);
      check({o_port_a_full_or_in_ready, o_port_b_full_or_in_ready}, 36'h0, "short reset");
      $display("t_power_up done");
   endtask

   task automatic t_config(input logic pin, input logic [2:0] fs_spm);
      int n;
      mreset(1'b1, 1'b1, 6, pin, fs_spm);
      @(posedge i_port_a_clock);
      check(o_port_a_full_or_in_ready, 1'b0, "ready after one edge");
      @(posedge i_port_a_clock);
      check(o_port_a_full_or_in_ready, 1'b0, "ready at second edge");
      for (n = 0; n < 4 && o_port_a_full_or_in_ready !== 1'b1; n++)
         cyc(1);
      check(o_port_a_full_or_in_ready, 1'b1, "fifo1 ready");
      check({o_endian_select, o_offset_select_0, o_offset_select_1, o_serial_program_mode_n},
            {pin, fs_spm}, "captured config");
      check({o_fifo2_almost_empty_offset, o_fifo2_almost_full_offset}, 36'h0, "offsets");
      check({o_fifo1_fall_through_timing, o_fifo2_fall_through_timing}, {~pin, ~pin},
            "timing mode");
      cyc(15);
      check(o_port_b_full_or_in_ready, 1'b1, "fifo2 ready");
      $display("t_config done");
   endtask

   task automatic t_mailbox();
      u_bfmr_bus_model.b_cycle(1'b0, 1'b1, 1'b0, 1'b1, '0);
      u_bfmr_bus_model.a_cycle(1'b0, 1'b1, 1'b1, 1'b1, 36'h123456789);
      u_bfmr_bus_model.a_cycle(1'b1, 1'b1, 1'b0, 1'b0, '0);
      check(o_mailbox1_flag_n, 1'b0, "mailbox1 written");
      check(o_port_b_data, 36'h123456789, "mailbox1 on port B");
      check(o_port_b_data_oe_n, 1'b0, "port B driving");
      u_bfmr_bus_model.b_cycle(1'b0, 1'b1, 1'b1, 1'b1, '0);
      u_bfmr_bus_model.b_cycle(1'b0, 1'b1, 1'b0, 1'b0, '0);
      check(o_mailbox1_flag_n, 1'b1, "mailbox1 read");
      check(o_port_b_data, i_fifo1_read_data, "fifo data on port B");
      u_bfmr_bus_model.b_cycle(1'b0, 1'b0, 1'b0, 1'b0, '0);
      cyc(3);
      check(o_port_b_data_oe_n, 1'b1, "port B floats");
      u_bfmr_bus_model.a_cycle(1'b0, 1'b0, 1'b0, 1'b1, '0);
      u_bfmr_bus_model.b_cycle(1'b0, 1'b0, 1'b1, 1'b1, 36'h0fedcba98);
      u_bfmr_bus_model.b_cycle(1'b1, 1'b0, 1'b0, 1'b0, '0);
      check(o_mailbox2_flag_n, 1'b0, "mailbox2 written");
      check(o_port_a_data, 36'h0fedcba98, "mailbox2 on port A");
      check(o_port_a_data_oe_n, 1'b0, "port A driving");
      u_bfmr_bus_model.a_cycle(1'b0, 1'b0, 1'b1, 1'b1, '0);
      u_bfmr_bus_model.a_cycle(1'b0, 1'b1, 1'b0, 1'b0, '0);
      cyc(3);
      check(o_mailbox2_flag_n, 1'b1, "mailbox2 read");
      check(o_port_a_data_oe_n, 1'b1, "port A floats");
      u_bfmr_bus_model.a_cycle(1'b0, 1'b1, 1'b1, 1'b1, 36'h0cafe0001);
      u_bfmr_bus_model.a_cycle(1'b1, 1'b1, 1'b0, 1'b0, '0);
      check(o_mailbox1_flag_n, 1'b0, "mailbox1 rewritten");
      // move the fifo1 write pointer so the reset below has something to clear
      u_bfmr_bus_model.a_cycle(1'b0, 1'b1, 1'b1, 1'b0, 36'h1);
      u_bfmr_bus_model.a_cycle(1'b1, 1'b1, 1'b0, 1'b0, '0);
      check({o_fifo1_write_ptr, o_port_b_empty_or_out_ready}, 36'h3, "fifo1 written");
      mreset(1'b1, 1'b0, 6, 1'b1, 3'h1);
      $display("t_mailbox done");
   endtask

   initial begin
      cyc(3);
      i_reset = 1'b0;
      cyc(2);
      t_power_up();
      t_config(1'b0, 3'h5);
      t_config(1'b1, 3'h2);
      t_mailbox();
      end_sim();
   end

   initial begin
      #50000;
      num_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule
